//--- rtl/gp8_port.sv
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Direction bit one makes pin output
// - Output pin drives its data latch bit
// - Latch write appears on output pins immediately
// - Output pin read returns latch
// - Direction bit zero makes pin input
// - Latch write on input pin not driven
// - Input read gives pin; RMW gives latch
// - Peripheral drives pin; read pin, RMW latch
// - Peripheral input pin read gives pin level
// - Reset clears all direction bits
// - Standby with select bit forces Hi-Z
// - Standby Hi-Z blocks input, holds low
// - Enabled interrupt pins keep input open
// - Select bit zero keeps pin state
// - Pull-up bit one connects pull-up
// - Pull-up off while pin drives low
// - Open-drain output one stays Hi-Z
module gp8_port #(
  parameter logic [gp8_pkg::PORT_W-1:0] OPEN_DRAIN_MASK = gp8_pkg::OPEN_DRAIN_MASK_DEF,
  parameter logic [gp8_pkg::PORT_W-1:0] IRQ_PIN_MASK = gp8_pkg::IRQ_PIN_MASK_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gp8_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [gp8_pkg::WB_DW-1:0] wb_dat_i,
  input wire logic wb_rmw_i,
  output logic [gp8_pkg::WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic standby_i,
  input wire logic [gp8_pkg::PORT_W-1:0] irq_in_en_i,
  input wire logic [gp8_pkg::PORT_W-1:0] periph_oe_i,
  input wire logic [gp8_pkg::PORT_W-1:0] periph_out_i,
  output logic [gp8_pkg::PORT_W-1:0] periph_in_o,
  input wire logic [gp8_pkg::PORT_W-1:0] pad_i,
  output logic [gp8_pkg::PORT_W-1:0] pad_o,
  output logic [gp8_pkg::PORT_W-1:0] pad_oe_o,
  output logic [gp8_pkg::PORT_W-1:0] pullup_en_o
);
  import gp8_pkg::*;

  if ((IRQ_PIN_MASK & ~IRQ_PIN_MASK_DEF) != 8'h00)
  begin : g_bad_mask
    $error("IRQ_PIN_MASK names a pin with no interrupt input");
  end

  // Registers sit in the low byte lane and are picked by address bits 3:2
  if (WB_DW < PORT_W || WB_AW < 4)
  begin : g_bad_bus
    $error("bus too narrow for the port registers");
  end

  typedef struct packed {
    logic [PORT_W-1:0] latch;
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] pull;
    logic hiz_sel;
    logic ack;
    logic [WB_DW-1:0] rdata;
    logic [PORT_W-1:0] pad_out;
    logic [PORT_W-1:0] pad_oe;
    logic [PORT_W-1:0] pull_out;
    logic [PORT_W-1:0] per_in;
  } gp8_state_type;

  gp8_state_type st;
  gp8_state_type next_st;

  function automatic logic [1:0] reg_index(input logic [WB_AW-1:0] adr);
    return adr[3:2];
  endfunction

  logic req;
  logic block_now;
  logic [PORT_W-1:0] pin_val;
  logic [PORT_W-1:0] irq_keep;
  logic hiz_next;
  logic [PORT_W-1:0] drv_val;
  logic [PORT_W-1:0] drv_en;

  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign irq_keep = irq_in_en_i & IRQ_PIN_MASK;
  assign block_now = standby_i && st.hiz_sel;
  // Blocked inputs read low so a floating pad cannot leak
  assign pin_val = pad_i & ~({PORT_W{block_now}} & ~irq_keep);

  always_comb
  begin
    next_st = st;
    next_st.ack = req;
    if (req && wb_we_i && wb_sel_i[0])
    begin
      unique case (gp8_reg_type'(reg_index(wb_adr_i)))
        REG_DATA: next_st.latch = wb_dat_i[PORT_W-1:0];
        REG_DIR: next_st.dir = wb_dat_i[PORT_W-1:0];
        REG_PULL: next_st.pull = wb_dat_i[PORT_W-1:0];
        REG_CTRL: next_st.hiz_sel = wb_dat_i[CTRL_HIZ_SEL_BIT];
      endcase
    end
    if (req && !wb_we_i)
    begin
      next_st.rdata = '0;
      unique case (gp8_reg_type'(reg_index(wb_adr_i)))
        REG_DATA:
        begin
          // RMW reads the latch; otherwise output port bits read the latch and everything else the pin
          if (wb_rmw_i)
          begin
            next_st.rdata[PORT_W-1:0] = st.latch;
          end
          else
          begin
            next_st.rdata[PORT_W-1:0] = (st.latch & st.dir & ~periph_oe_i)
              | (pin_val & ~(st.dir & ~periph_oe_i));
          end
        end
        REG_DIR: next_st.rdata[PORT_W-1:0] = st.dir;
        REG_PULL: next_st.rdata[PORT_W-1:0] = st.pull;
        REG_CTRL: next_st.rdata[CTRL_HIZ_SEL_BIT] = st.hiz_sel;
      endcase
    end
    // Pad outputs follow the register values being written, so a write shows at
    // the pin on the same edge that it lands in the latch
    hiz_next = standby_i && next_st.hiz_sel;
    drv_val = (periph_oe_i & periph_out_i) | (~periph_oe_i & next_st.latch);
    drv_en = (periph_oe_i | next_st.dir) & ~{PORT_W{hiz_next}};
    next_st.pad_oe = drv_en & ~(OPEN_DRAIN_MASK & drv_val);
    next_st.pad_out = drv_val & ~OPEN_DRAIN_MASK;
    next_st.pull_out = next_st.pull & ~(next_st.pad_oe & ~next_st.pad_out);
    next_st.per_in = pin_val;
    if (rst_i)
    begin
      next_st = '0;
      next_st.latch = RST_DATA;
      next_st.dir = RST_DIR;
      next_st.pull = RST_PULL;
      next_st.hiz_sel = RST_HIZ_SEL;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st <= next_st;
  end

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign pad_o = st.pad_out;
  assign pad_oe_o = st.pad_oe;
  assign pullup_en_o = st.pull_out;
  assign periph_in_o = st.per_in;

  // Shared pins rely on software keeping direction and peripheral enables apart;
  // a peripheral output enable simply wins over the direction bit.

  property p_out_drive;
    @(posedge clk_i) disable iff (rst_i)
    !($past(standby_i) && st.hiz_sel) |->
      ((pad_oe_o & st.dir & ~$past(periph_oe_i) & ~OPEN_DRAIN_MASK)
        == (st.dir & ~$past(periph_oe_i) & ~OPEN_DRAIN_MASK))
      && ((pad_o & st.dir & ~$past(periph_oe_i)) == (st.latch & st.dir
        & ~$past(periph_oe_i) & ~OPEN_DRAIN_MASK));
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("output pin not driving latch");

  property p_in_off;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |-> (pad_oe_o & ~st.dir & ~$past(periph_oe_i)) == 8'h00;
  endproperty
  a_in_off: assert property (p_in_off) else $error("input pin is driven");

  property p_write_latch;
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && wb_we_i && wb_sel_i[0] && reg_index(wb_adr_i) == 2'b00)
      |=> st.latch == $past(wb_dat_i[PORT_W-1:0]);
  endproperty
  a_write_latch: assert property (p_write_latch) else $error("latch write lost");

  property p_rmw_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && wb_rmw_i && reg_index(wb_adr_i) == 2'b00)
      ##1 (st.latch == $past(st.latch)) |-> wb_ack_o && wb_dat_o[PORT_W-1:0] == st.latch;
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("RMW read not latch");

  property p_pin_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && !wb_rmw_i && reg_index(wb_adr_i) == 2'b00) |=>
      (wb_dat_o[PORT_W-1:0] & ~$past(st.dir & ~periph_oe_i))
        == ($past(pin_val) & ~$past(st.dir & ~periph_oe_i));
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("input read not pin");

  property p_reset_dir;
    @(posedge clk_i)
    $past(rst_i) |-> st.dir == 8'h00 && pad_oe_o == 8'h00 && !wb_ack_o;
  endproperty
  a_reset_dir: assert property (p_reset_dir) else $error("direction not cleared");

  property p_hiz;
    @(posedge clk_i) disable iff (rst_i)
    ($past(standby_i) && st.hiz_sel) |-> pad_oe_o == 8'h00;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven in standby");

  property p_block;
    @(posedge clk_i) disable iff (rst_i)
    $past(standby_i && st.hiz_sel) |-> periph_in_o == $past(pad_i & irq_keep);
  endproperty
  a_block: assert property (p_block) else $error("standby input not blocked");

  property p_pull_low;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |-> (pullup_en_o & pad_oe_o & ~pad_o) == 8'h00;
  endproperty
  a_pull_low: assert property (p_pull_low) else $error("pull-up on low pin");

  property p_open_drain;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |-> (pad_o & OPEN_DRAIN_MASK) == 8'h00;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain driven high");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_pull_on;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |-> pullup_en_o == (st.pull & ~(pad_oe_o & ~pad_o));
  endproperty
  a_pull_on: assert property (p_pull_on) else $error("pull-up enable lost");

  property p_hiz_keep;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !st.hiz_sel |->
      (pad_oe_o & ~OPEN_DRAIN_MASK) == ((st.dir | $past(periph_oe_i)) & ~OPEN_DRAIN_MASK);
  endproperty
  a_hiz_keep: assert property (p_hiz_keep) else $error("standby changed pin state");

  property p_periph_drive;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |->
      (pad_o & $past(periph_oe_i)) == ($past(periph_oe_i & periph_out_i) & ~OPEN_DRAIN_MASK);
  endproperty
  a_periph_drive: assert property (p_periph_drive) else $error("peripheral value lost");

  property p_od_release;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |->
      (pad_oe_o & OPEN_DRAIN_MASK & st.latch & ~$past(periph_oe_i)) == 8'h00;
  endproperty
  a_od_release: assert property (p_od_release) else $error("open drain one driven");

  // Register readback, writes and holds, bus bookkeeping, and further pin checks
  property p_dir_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && reg_index(wb_adr_i) == 2'b01) |=> wb_dat_o == WB_DW'($past(st.dir));
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction readback wrong");

  property p_pull_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && reg_index(wb_adr_i) == 2'b10) |=> wb_dat_o == WB_DW'($past(st.pull));
  endproperty
  a_pull_read: assert property (p_pull_read) else $error("pull-up readback wrong");

  property p_ctrl_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && reg_index(wb_adr_i) == 2'b11) |=>
      wb_dat_o == (WB_DW'($past(st.hiz_sel)) << CTRL_HIZ_SEL_BIT);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

  property p_ack_req;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

  property p_rdata_hold;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(req && !wb_we_i) |-> $stable(wb_dat_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_dir_write;
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && wb_we_i && wb_sel_i[0] && reg_index(wb_adr_i) == 2'b01)
      |=> st.dir == $past(wb_dat_i[PORT_W-1:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_pull_write;
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && wb_we_i && wb_sel_i[0] && reg_index(wb_adr_i) == 2'b10)
      |=> st.pull == $past(wb_dat_i[PORT_W-1:0]);
  endproperty
  a_pull_write: assert property (p_pull_write) else $error("pull-up write lost");

  property p_ctrl_write;
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && wb_we_i && wb_sel_i[0] && reg_index(wb_adr_i) == 2'b11)
      |=> st.hiz_sel == $past(wb_dat_i[CTRL_HIZ_SEL_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_latch_hold;
    @(posedge clk_i) disable iff (rst_i)
    !(req && wb_we_i && wb_sel_i[0] && reg_index(wb_adr_i) == 2'b00)
      |=> st.latch == $past(st.latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed unwritten");

  property p_dir_hold;
    @(posedge clk_i) disable iff (rst_i)
    !(req && wb_we_i && wb_sel_i[0] && reg_index(wb_adr_i) == 2'b01)
      |=> st.dir == $past(st.dir);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed unwritten");

  property p_input_write;
    @(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && wb_we_i && reg_index(wb_adr_i) == 2'b00) |->
      (pad_oe_o & ~st.dir & ~$past(periph_oe_i)) == 8'h00;
  endproperty
  a_input_write: assert property (p_input_write) else $error("input pin driven by write");

  property p_periph_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && !wb_rmw_i && reg_index(wb_adr_i) == 2'b00) |=>
      (wb_dat_o[PORT_W-1:0] & $past(periph_oe_i)) == ($past(pin_val) & $past(periph_oe_i));
  endproperty
  a_periph_read: assert property (p_periph_read) else $error("peripheral pin read wrong");

  property p_block_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && !wb_rmw_i && reg_index(wb_adr_i) == 2'b00
      && standby_i && st.hiz_sel) |=>
      (wb_dat_o[PORT_W-1:0] & ~$past(st.dir & ~periph_oe_i | irq_keep)) == 8'h00;
  endproperty
  a_block_read: assert property (p_block_read) else $error("blocked pin read high");

  property p_per_in_open;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(standby_i && st.hiz_sel) |-> periph_in_o == $past(pad_i);
  endproperty
  a_per_in_open: assert property (p_per_in_open) else $error("open input not passed");

  property p_reset_out;
    @(posedge clk_i)
    $past(rst_i) |-> pad_o == 8'h00 && pullup_en_o == 8'h00 && periph_in_o == 8'h00;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not cleared");

  c_rmw: cover property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && wb_rmw_i ##1 wb_ack_o);
  c_hiz: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(standby_i) && st.hiz_sel && st.dir != 8'h00);
  c_write: cover property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && st.dir != 8'h00);
  c_periph: cover property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && periph_oe_i != 8'h00);
  c_pull: cover property (@(posedge clk_i) disable iff (rst_i)
    pullup_en_o != 8'h00 && pad_oe_o != 8'h00);
endmodule // gp8_port

//--- rtl/gp8_pkg.sv
package gp8_pkg;
  localparam int PORT_W = 8;
  localparam int WB_DW = 32;
  localparam int WB_AW = 4;
  // Byte offsets of the registers
  localparam logic [WB_AW-1:0] OFS_DATA = 4'h0;
  localparam logic [WB_AW-1:0] OFS_DIR = 4'h4;
  localparam logic [WB_AW-1:0] OFS_PULL = 4'h8;
  localparam logic [WB_AW-1:0] OFS_CTRL = 4'hC;
  // Control register fields
  localparam int CTRL_HIZ_SEL_BIT = 0;
  // Reset values
  localparam logic [PORT_W-1:0] RST_DATA = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIR = 8'h00;
  localparam logic [PORT_W-1:0] RST_PULL = 8'h00;
  localparam logic RST_HIZ_SEL = 1'b0;
  // Pins whose input may stay open in standby: two interrupt pins, counter clock, trigger
  localparam logic [PORT_W-1:0] IRQ_PIN_MASK_DEF = 8'h93;
  localparam logic [PORT_W-1:0] OPEN_DRAIN_MASK_DEF = 8'h00;
  typedef enum logic [1:0] {
    REG_DATA = 2'b00,
    REG_DIR = 2'b01,
    REG_PULL = 2'b10,
    REG_CTRL = 2'b11
  } gp8_reg_type;
endpackage

//--- verif/gp8_pins.sv
`timescale 1ns/1ps
// Pads and the world beyond them: our drive wins, then an outside driver,
// then the pull-up; an undriven pin toggles so no stale level can pass.
module gp8_pins (
  input wire logic clk_i,
  input wire logic [7:0] pad_o_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic [7:0] pullup_en_i,
  input wire logic [7:0] ext_oe_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pad_i_o
);
  logic [7:0] float_pat = 8'h55;
  always_ff @(posedge clk_i) float_pat <= ~float_pat;
  always_comb
  begin
    pad_i_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ext_oe_i & ext_val_i)
      | (~pad_oe_i & ~ext_oe_i & (pullup_en_i | float_pat));
  end
endmodule // gp8_pins

//--- verif/gp8_port_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module gp8_port_tb;
  import gp8_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rmw = 1'b0, standby = 1'b0, ack;
  logic [WB_AW-1:0] adr = 4'h0;
  logic [WB_DW-1:0] dat = 32'h0, rdat;
  logic [7:0] irq_en = 8'h00, p_oe = 8'h00, p_out = 8'h00, ext_oe = 8'h00, ext_val = 8'h00;
  logic [7:0] pad_in, pad_out, pad_oe, pull_en, per_in, q;
  logic [7:0] od_pad_out, od_pad_oe;
  int err_total = 0;
  int checks_done = 0;
  always #5 clk_i = ~clk_i;
  gp8_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_rmw_i(rmw), .wb_dat_o(rdat),
    .wb_ack_o(ack), .standby_i(standby), .irq_in_en_i(irq_en), .periph_oe_i(p_oe),
    .periph_out_i(p_out), .periph_in_o(per_in), .pad_i(pad_in), .pad_o(pad_out),
    .pad_oe_o(pad_oe), .pullup_en_o(pull_en));
  // Upper nibble open drain, to see a latched one release the pin
  gp8_port #(.OPEN_DRAIN_MASK(8'hF0)) dut_od (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
    .wb_rmw_i(rmw), .wb_dat_o(), .wb_ack_o(), .standby_i(standby), .irq_in_en_i(irq_en),
    .periph_oe_i(p_oe), .periph_out_i(p_out), .periph_in_o(), .pad_i(pad_in),
    .pad_o(od_pad_out), .pad_oe_o(od_pad_oe), .pullup_en_o());
  gp8_pins pins (.clk_i(clk_i), .pad_o_i(pad_out), .pad_oe_i(pad_oe), .pullup_en_i(pull_en),
    .ext_oe_i(ext_oe), .ext_val_i(ext_val), .pad_i_o(pad_in));
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic m);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h000000, d}; rmw <= m;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic m, input logic [7:0] e);
    bus(1'b0, a, 8'h00, m);
    `CHK("read data", e, q)
  endtask
  // Pin paths are registered from inputs one cycle old, so give them room
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic t_output;
    bus(1'b1, OFS_DIR, 8'hFF, 1'b0);
    bus(1'b1, OFS_DATA, 8'hA5, 1'b0);
    #1;
    `CHK("pad_o", 8'hA5, pad_out)
    `CHK("pad_oe", 8'hFF, pad_oe)
    `CHK("od pad_oe", 8'h5F, od_pad_oe)
    `CHK("od pad_o", 8'h05, od_pad_out)
    rd(OFS_DATA, 1'b0, 8'hA5);
  endtask
  task automatic t_input;
    bus(1'b1, OFS_DIR, 8'h0F, 1'b0);
    ext_oe <= 8'hF0;
    ext_val <= 8'h50;
    bus(1'b1, OFS_DATA, 8'h3C, 1'b0);
    settle();
    `CHK("pad_oe", 8'h0F, pad_oe)
    rd(OFS_DATA, 1'b0, 8'h5C);
    rd(OFS_DATA, 1'b1, 8'h3C);
  endtask
  task automatic t_periph;
    @(posedge clk_i);
    ext_oe <= 8'h00;
    p_oe <= 8'hF0;
    p_out <= 8'hA0;
    settle();
    `CHK("pad_oe", 8'hFF, pad_oe)
    `CHK("pad_o", 8'hAC, pad_out)
    rd(OFS_DATA, 1'b0, 8'hAC);
    rd(OFS_DATA, 1'b1, 8'h3C);
    p_oe <= 8'h00;
  endtask
  task automatic t_pull;
    bus(1'b1, OFS_PULL, 8'hFF, 1'b0);
    bus(1'b1, OFS_DIR, 8'hFF, 1'b0);
    settle();
    `CHK("pullup", 8'h3C, pull_en)
    bus(1'b1, OFS_DIR, 8'h00, 1'b0);
    settle();
    `CHK("pullup", 8'hFF, pull_en)
  endtask
  task automatic t_standby;
    bus(1'b1, OFS_DIR, 8'hFF, 1'b0);
    standby <= 1'b1;
    settle();
    `CHK("pad_oe", 8'hFF, pad_oe)
    `CHK("pad_o", 8'h3C, pad_out)
    bus(1'b1, OFS_CTRL, 8'h01, 1'b0);
    rd(OFS_CTRL, 1'b0, 8'h01);
    irq_en <= 8'h03;
    settle();
    `CHK("pad_oe", 8'h00, pad_oe)
    ext_oe <= 8'hFF;
    ext_val <= 8'hFF;
    settle();
    `CHK("periph_in", 8'h03, per_in)
    irq_en <= 8'hFF;
    settle();
    `CHK("periph_in", 8'h93, per_in)
    standby <= 1'b0;
    settle();
    `CHK("pad_oe", 8'hFF, pad_oe)
  endtask
  task automatic t_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK("pad_oe", 8'h00, pad_oe)
    rd(OFS_DIR, 1'b0, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK("pad_oe", 8'h00, pad_oe)
    rd(OFS_DIR, 1'b0, 8'h00);
    t_output();
    t_input();
    t_periph();
    t_pull();
    t_standby();
    t_reset();
    report_and_stop();
  end
  // The whole run needs well under a thousand cycles
  initial
  begin
    #20000;
    err_total++;
    report_and_stop();
  end
endmodule // gp8_port_tb
